// ### hw/csr_core_regs.sv
// Status flag word, machine control, fault address, page directory base
// and next instruction offset of the core, with the checks they steer.
// Assumes an APB master on pclk and an execution datapath on the same clock;
// only the maskable interrupt pin arrives asynchronously.
// What this block does
// RULE1: Instruction offset advances unless a transfer reloads it
// RULE2: Carry flag from add carry or sub borrow
// RULE3: Parity flag set for even low-byte ones
// RULE4: Nibble carry from bit three
// RULE5: Zero flag on zero result; sign copies top
// RULE6: Trap flag raises step interrupt, then clears
// RULE7: Maskable pin serviced only with enable flag
// RULE8: Direction flag selects index increment or decrement
// RULE9: Overflow when sign carry-in differs from carry-out
// RULE10: IO privilege gates IO and enable changes
// RULE11: Nested flag marks nested task in protected mode
// RULE12: Resume flag suppresses next debug fault
// RULE13: V86 mode real-style segments, privileged opcodes fault
// RULE14: Alignment fault needs flag and mask bit
// RULE15: Page fault captures full linear address
// RULE16: Directory base 4K aligned, low twelve reserved
// RULE17: Control registers readable always, writable at level zero or while the protection bit is clear
// RULE18: Protection bit selects protected or real mode
// RULE19: Monitor plus task-switched makes WAIT fault seven
// RULE20: Trap-all bit faults every floating instruction
// RULE21: Task switch sets bit; floating instruction then faults
// RULE22: Write protect bit faults supervisor read-only writes
// RULE23: Cache disable stops allocation, hits still served
// RULE24: Reserved bits ignore writes, read fixed values
`timescale 1ns/1ps
`default_nettype none

module csr_core_regs
  import csr_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Privilege of the running code
  input  wire logic [1:0]  cur_priv_level,
  // Instruction retire and control transfers
  input  wire logic        instr_retire,
  input  wire logic [3:0]  instr_len,
  input  wire logic        flow_load,
  input  wire logic [31:0] flow_target,
  // Arithmetic operands
  input  wire logic        alu_valid,
  input  wire logic        alu_sub,
  input  wire logic [31:0] alu_op_a,
  input  wire logic [31:0] alu_op_b,
  // Interrupt return and task switch flag loads
  input  wire logic        iret_load,
  input  wire logic        task_switch,
  input  wire logic [31:0] new_flags,
  // Maskable interrupt pin
  input  wire logic        maskable_irq_pin,
  output logic             irq_service,
  // Event checks
  input  wire logic        io_instr,
  input  wire logic        debug_hit,
  input  wire logic        priv_opcode,
  input  wire logic        mem_access,
  input  wire logic        mem_misaligned,
  input  wire logic        mem_write,
  input  wire logic        page_read_only,
  input  wire logic        page_fault,
  input  wire logic [31:0] fault_linear_addr,
  input  wire logic        fpu_instr,
  input  wire logic        wait_instr,
  // Check results
  output logic             step_irq,
  output logic             io_direct_ok,
  output logic             io_bitmap_chk,
  output logic             io_gp_fault,
  output logic             debug_fault,
  output logic             priv_gp_fault,
  output logic             align_fault,
  output logic             wp_fault,
  output logic             dna_fault,
  // Mode levels
  output logic             protected_mode_on,
  output logic             paging_enable,
  output logic             real_style_segments,
  output logic             string_dir_dec,
  output logic             nested_job,
  output logic             cache_alloc_en,
  output logic [31:0]      next_instr_offset
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : byte_merge

  function automatic logic [31:0] mask_fix(input logic [31:0] v,
                                           input logic [31:0] wmask,
                                           input logic [31:0] fixed);
    return (v & wmask) | fixed;
  endfunction : mask_fix

  csr_state_t r;
  csr_state_t s_nxt;

  logic        prot;
  logic        cpl_zero;
  logic        io_allowed;
  logic        apb_acc;
  logic        addr_ok;
  logic        wr_ok;
  logic        wr_go;
  logic [32:0] sum33;
  logic [31:0] opb_eff;
  logic [31:0] res;
  logic        carry_sign;
  logic [31:0] wv;
  logic [31:0] fl;
  logic [31:0] pv;

  assign prot       = r.mctl[CSR_MB_PROT];
  assign cpl_zero   = (cur_priv_level == 2'b00);
  assign io_allowed = cur_priv_level <= r.flags[CSR_FB_IO_PRIVILEGE_LEVEL +: 2];

  // ****************************************************************
  // APB decode
  // ****************************************************************
  assign apb_acc = psel & penable;
  always_comb begin
    addr_ok = 1'b0;
    wr_ok   = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      addr_ok = 1'b0;
    end else if (paddr == CSR_OFS_FLAGS) begin
      addr_ok = 1'b1;
      wr_ok   = 1'b1;
    end else if (paddr == CSR_OFS_MCTL || paddr == CSR_OFS_FADDR ||
                 paddr == CSR_OFS_PDBR) begin
      addr_ok = 1'b1;
      wr_ok   = !prot || cpl_zero;  // see RULE17
    end else if (paddr == CSR_OFS_NIP) begin
      addr_ok = 1'b1;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = apb_acc & (!addr_ok | (pwrite & !wr_ok));
  assign wr_go   = apb_acc & pwrite & addr_ok & wr_ok;
  assign wv      = pwdata;

  // ****************************************************************
  // Arithmetic flag evaluation
  // ****************************************************************
  always_comb begin
    opb_eff    = alu_sub ? ~alu_op_b : alu_op_b;
    sum33      = {1'b0, alu_op_a} + {1'b0, opb_eff} + {32'h0000_0000, alu_sub};
    res        = sum33[31:0];
    carry_sign = alu_op_a[31] ^ opb_eff[31] ^ res[31];
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_nxt = r;
    fl    = r.flags;
    pv    = byte_merge(r.flags, wv, pstrb);

    // Read data captured in the setup cycle
    if (psel && !penable && !pwrite) begin
      if (paddr == CSR_OFS_FLAGS) begin
        s_nxt.prdata = r.flags;
      end else if (paddr == CSR_OFS_MCTL) begin
        s_nxt.prdata = r.mctl;
      end else if (paddr == CSR_OFS_FADDR) begin
        s_nxt.prdata = r.faddr;
      end else if (paddr == CSR_OFS_PDBR) begin
        s_nxt.prdata = r.pdbr;
      end else if (paddr == CSR_OFS_NIP) begin
        s_nxt.prdata = r.nip;
      end else begin
        s_nxt.prdata = CSR_WORD_RST;
      end
    end

    // Software writes to the flag word act as a flag pop
    if (wr_go && paddr == CSR_OFS_FLAGS) begin
      if (prot && !io_allowed) begin
        pv[CSR_FB_IEN] = r.flags[CSR_FB_IEN];  // see RULE10
      end
      if (prot && !cpl_zero) begin
        pv[CSR_FB_IO_PRIVILEGE_LEVEL +: 2] = r.flags[CSR_FB_IO_PRIVILEGE_LEVEL +: 2];
      end
      pv[CSR_FB_V86] = r.flags[CSR_FB_V86];  // see RULE13
      fl = mask_fix(pv, CSR_FLAGS_WMASK, CSR_FLAGS_FIXED);  // see RULE24
    end

    // Interrupt return and task switch reload the word; V86 loads only on a task switch or at level zero
    if (iret_load || task_switch) begin
      fl = mask_fix(new_flags, CSR_FLAGS_WMASK, CSR_FLAGS_FIXED);
      if (task_switch || cpl_zero) begin
        fl[CSR_FB_V86] = new_flags[CSR_FB_V86];  // see RULE13
      end
    end

    if (alu_valid) begin
      fl[CSR_FB_CARRY]  = alu_sub ? !sum33[32] : sum33[32];  // see RULE2
      fl[CSR_FB_PARITY] = ~^res[7:0];  // see RULE3
      fl[CSR_FB_NIBBLE] = alu_op_a[4] ^ alu_op_b[4] ^ res[4];  // see RULE4
      fl[CSR_FB_ZERO]   = (res == 32'h0000_0000);  // see RULE5
      fl[CSR_FB_SIGN]   = res[31];  // see RULE5
      fl[CSR_FB_OVF]    = carry_sign ^ sum33[32];  // see RULE9
    end

    // Single step fires after the instruction retires with trap set
    s_nxt.step_irq = instr_retire & r.flags[CSR_FB_TRAP];  // see RULE6
    if (s_nxt.step_irq) begin
      fl[CSR_FB_TRAP] = 1'b0;  // see RULE6
    end

    // Resume lasts for one instruction
    s_nxt.debug_fault = debug_hit & !r.flags[CSR_FB_RESUME];  // see RULE12
    if (instr_retire && !(wr_go && paddr == CSR_OFS_FLAGS) && !iret_load &&
        !task_switch) begin
      fl[CSR_FB_RESUME] = 1'b0;
    end
    s_nxt.flags = fl;

    // Machine control
    if (wr_go && paddr == CSR_OFS_MCTL) begin
      s_nxt.mctl = mask_fix(byte_merge(r.mctl, wv, pstrb),
                            CSR_MCTL_WMASK, CSR_MCTL_FIXED);  // see RULE24
    end
    if (task_switch) begin
      s_nxt.mctl[CSR_MB_TSW] = 1'b1;  // see RULE21
    end

    // Fault address: hardware capture wins over a write
    if (wr_go && paddr == CSR_OFS_FADDR) begin
      s_nxt.faddr = byte_merge(r.faddr, wv, pstrb);
    end
    if (page_fault && r.mctl[CSR_MB_PAGE] && prot) begin
      s_nxt.faddr = fault_linear_addr;  // see RULE15
    end

    if (wr_go && paddr == CSR_OFS_PDBR) begin
      s_nxt.pdbr = byte_merge(r.pdbr, wv, pstrb) & CSR_PDBR_WMASK;  // see RULE16
    end

    // Next instruction offset
    if (flow_load) begin
      s_nxt.nip = flow_target;  // see RULE1
    end else if (instr_retire) begin
      s_nxt.nip = r.nip + {28'h000_0000, instr_len};  // see RULE1
    end

    // Maskable interrupt pin: three stages, change taken when last two agree
    s_nxt.irq_sync = {r.irq_sync[1:0], maskable_irq_pin};
    if (r.irq_sync[1] == r.irq_sync[2]) begin
      s_nxt.irq_lvl = r.irq_sync[2];
    end
    s_nxt.irq_service = r.irq_lvl & r.flags[CSR_FB_IEN];  // see RULE7

    // IO permission
    s_nxt.io_direct_ok  = io_instr & (!prot || (io_allowed && !r.flags[CSR_FB_V86]));
    s_nxt.io_bitmap_chk = io_instr & prot & (!io_allowed || r.flags[CSR_FB_V86]);  // see RULE10
    s_nxt.io_gp_fault   = io_instr & prot & !io_allowed & !r.flags[CSR_FB_V86];

    s_nxt.priv_gp_fault = priv_opcode & prot & r.flags[CSR_FB_V86];  // see RULE13

    s_nxt.align_fault = mem_access & mem_misaligned & r.flags[CSR_FB_ALIGN] &
                        r.mctl[CSR_MB_AMASK];  // see RULE14
    s_nxt.wp_fault = mem_access & mem_write & page_read_only &
                     (r.mctl[CSR_MB_WP] || cur_priv_level == 2'b11);  // see RULE22

    s_nxt.dna_fault = (fpu_instr & (r.mctl[CSR_MB_FPTRAP] | r.mctl[CSR_MB_TSW])) |  // see RULE20
                      (wait_instr & r.mctl[CSR_MB_MON] & r.mctl[CSR_MB_TSW]);  // see RULE19
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.flags         <= CSR_FLAGS_RST;
      r.mctl          <= CSR_MCTL_RST;
      r.faddr         <= CSR_WORD_RST;
      r.pdbr          <= CSR_WORD_RST;
      r.nip           <= CSR_WORD_RST;
      r.prdata        <= CSR_WORD_RST;
      r.irq_sync      <= 3'h0;
      r.irq_lvl       <= 1'b0;
      r.irq_service   <= 1'b0;
      r.step_irq      <= 1'b0;
      r.io_direct_ok  <= 1'b0;
      r.io_bitmap_chk <= 1'b0;
      r.io_gp_fault   <= 1'b0;
      r.debug_fault   <= 1'b0;
      r.priv_gp_fault <= 1'b0;
      r.align_fault   <= 1'b0;
      r.wp_fault      <= 1'b0;
      r.dna_fault     <= 1'b0;
    end else begin
      r <= s_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata              = r.prdata;
  assign irq_service         = r.irq_service;
  assign step_irq            = r.step_irq;
  assign io_direct_ok        = r.io_direct_ok;
  assign io_bitmap_chk       = r.io_bitmap_chk;
  assign io_gp_fault         = r.io_gp_fault;
  assign debug_fault         = r.debug_fault;
  assign priv_gp_fault       = r.priv_gp_fault;
  assign align_fault         = r.align_fault;
  assign wp_fault            = r.wp_fault;
  assign dna_fault           = r.dna_fault;
  assign protected_mode_on   = prot;  // see RULE18
  assign paging_enable       = r.mctl[CSR_MB_PAGE] & prot;
  assign real_style_segments = !prot | r.flags[CSR_FB_V86];  // see RULE18
  assign string_dir_dec      = r.flags[CSR_FB_DIR];  // see RULE8
  assign nested_job          = prot & r.flags[CSR_FB_NEST];  // see RULE11
  assign cache_alloc_en      = !r.mctl[CSR_MB_CDIS];  // see RULE23
  assign next_instr_offset   = r.nip;

endmodule : csr_core_regs

`default_nettype wire

// ### shared/csr_pkg.sv
// Constants and state types for the core status and control register block.
// Assumes a 32-bit APB slave on a single 40 MHz clock.
package csr_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] CSR_OFS_FLAGS = 8'h00;
  localparam logic [7:0] CSR_OFS_MCTL  = 8'h04;
  localparam logic [7:0] CSR_OFS_FADDR = 8'h08;
  localparam logic [7:0] CSR_OFS_PDBR  = 8'h0C;
  localparam logic [7:0] CSR_OFS_NIP   = 8'h10;

  // ****************************************************************
  // Flag word bit positions
  // ****************************************************************
  localparam int CSR_FB_CARRY  = 0;
  localparam int CSR_FB_PARITY = 2;
  localparam int CSR_FB_NIBBLE = 4;
  localparam int CSR_FB_ZERO   = 6;
  localparam int CSR_FB_SIGN   = 7;
  localparam int CSR_FB_TRAP   = 8;
  localparam int CSR_FB_IEN    = 9;
  localparam int CSR_FB_DIR    = 10;
  localparam int CSR_FB_OVF    = 11;
  localparam int CSR_FB_IO_PRIVILEGE_LEVEL   = 12;
  localparam int CSR_FB_NEST   = 14;
  localparam int CSR_FB_RESUME = 16;
  localparam int CSR_FB_V86    = 17;
  localparam int CSR_FB_ALIGN  = 18;

  // ****************************************************************
  // Machine control bit positions
  // ****************************************************************
  localparam int CSR_MB_PROT   = 0;
  localparam int CSR_MB_MON    = 1;
  localparam int CSR_MB_FPTRAP = 2;
  localparam int CSR_MB_TSW    = 3;
  localparam int CSR_MB_WP     = 16;
  localparam int CSR_MB_AMASK  = 18;
  localparam int CSR_MB_CDIS   = 30;
  localparam int CSR_MB_PAGE   = 31;

  // ****************************************************************
  // Writable masks and fixed values of reserved bits
  // ****************************************************************
  localparam logic [31:0] CSR_FLAGS_WMASK = 32'h0005_7FD5;
  localparam logic [31:0] CSR_FLAGS_FIXED = 32'h0000_0002;
  localparam logic [31:0] CSR_MCTL_WMASK  = 32'hC005_000F;
  localparam logic [31:0] CSR_MCTL_FIXED  = 32'h0000_0010;
  localparam logic [31:0] CSR_PDBR_WMASK  = 32'hFFFF_F000;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [31:0] CSR_FLAGS_RST = 32'h0000_0002;
  localparam logic [31:0] CSR_MCTL_RST  = 32'h0000_0010;
  localparam logic [31:0] CSR_WORD_RST  = 32'h0000_0000;

  typedef struct packed {
    logic [31:0] flags;
    logic [31:0] mctl;
    logic [31:0] faddr;
    logic [31:0] pdbr;
    logic [31:0] nip;
    logic [31:0] prdata;
    logic [2:0]  irq_sync;
    logic        irq_lvl;
    logic        irq_service;
    logic        step_irq;
    logic        io_direct_ok;
    logic        io_bitmap_chk;
    logic        io_gp_fault;
    logic        debug_fault;
    logic        priv_gp_fault;
    logic        align_fault;
    logic        wp_fault;
    logic        dna_fault;
  } csr_state_t;

endpackage : csr_pkg

// ### testbench/csr_core_regs_properties.sv
// Concurrent checks on the ports of the status and control register block.
// Assumes one clock, pclk, with presetn as its asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module csr_core_regs_properties
  import csr_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pslverr,
  input wire logic [1:0]  cur_priv_level,
  // Offset and flag loads
  input wire logic        instr_retire,
  input wire logic [3:0]  instr_len,
  input wire logic        flow_load,
  input wire logic [31:0] flow_target,
  input wire logic [31:0] next_instr_offset,
  input wire logic        iret_load,
  input wire logic        task_switch,
  // Interrupts
  input wire logic        maskable_irq_pin,
  input wire logic        irq_service,
  input wire logic        step_irq,
  // Event checks
  input wire logic        io_instr,
  input wire logic        io_direct_ok,
  input wire logic        io_bitmap_chk,
  input wire logic        mem_access,
  input wire logic        mem_misaligned,
  input wire logic        mem_write,
  input wire logic        page_read_only,
  input wire logic        align_fault,
  input wire logic        wp_fault,
  input wire logic        protected_mode_on
);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ****************************************
  // Offset and step interrupt
  // ****************************************
  sequence s_step_taken;
    instr_retire && !iret_load && !task_switch && !(psel && penable && pwrite) ##1 step_irq;
  endsequence

  a_offset_load: assert property (flow_load |=> next_instr_offset == $past(flow_target))
    else $error("offset not reloaded");
  a_offset_step: assert property (instr_retire && !flow_load |=>
    next_instr_offset == $past(next_instr_offset) + $past(instr_len))
    else $error("offset did not advance by length");
  a_step_once: assert property (s_step_taken |=> !step_irq)
    else $error("step interrupt repeated");

  // ****************************************
  // Gating of events
  // ****************************************
  a_irq_quiet: assert property (!maskable_irq_pin [*8] |=> !irq_service)
    else $error("service without request");
  a_io_split: assert property (io_instr |=> io_direct_ok != io_bitmap_chk)
    else $error("io outcome not exclusive");
  a_align_cause: assert property (align_fault |-> $past(mem_access && mem_misaligned))
    else $error("alignment fault without cause");
  a_wp_cause: assert property (wp_fault |->
    $past(mem_access && mem_write && page_read_only))
    else $error("write protect fault without cause");
  a_ctl_priv: assert property (psel && penable && pwrite && paddr == CSR_OFS_MCTL
    && protected_mode_on && cur_priv_level != 2'h0 |-> pslverr)
    else $error("unprivileged control write accepted");
  a_wp_user: assert property (mem_access && mem_write && page_read_only
    && protected_mode_on && cur_priv_level == 2'h3 |=> wp_fault)
    else $error("user write to read-only page passed");

endmodule : csr_core_regs_properties

bind csr_core_regs csr_core_regs_properties csr_chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pslverr(pslverr), .cur_priv_level(cur_priv_level),
  .instr_retire(instr_retire), .instr_len(instr_len), .flow_load(flow_load),
  .flow_target(flow_target), .next_instr_offset(next_instr_offset),
  .iret_load(iret_load), .task_switch(task_switch), .maskable_irq_pin(maskable_irq_pin),
  .irq_service(irq_service), .step_irq(step_irq), .io_instr(io_instr),
  .io_direct_ok(io_direct_ok), .io_bitmap_chk(io_bitmap_chk), .mem_access(mem_access),
  .mem_misaligned(mem_misaligned), .mem_write(mem_write), .page_read_only(page_read_only),
  .align_fault(align_fault), .wp_fault(wp_fault), .protected_mode_on(protected_mode_on)
);

`default_nettype wire

// ### testbench/csr_core_regs_tb.sv
// Self-checking bench for the status and control register block.
// Assumes an APB slave on pclk; waits on pready, never on a fixed latency.
`timescale 1ns/1ps
`default_nettype none

module csr_core_regs_tb
  import csr_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, flow_target = 32'h0, alu_op_a = 32'h0, alu_op_b = 32'h0;
  logic [31:0] new_flags = 32'h0, fault_linear_addr = 32'h0, prdata, next_instr_offset, q;
  logic [3:0]  pstrb = 4'hF, instr_len = 4'h3;
  logic [1:0]  cur_priv_level = 2'h0;
  logic        instr_retire = 1'b0, flow_load = 1'b0, alu_valid = 1'b0, alu_sub = 1'b0;
  logic        iret_load = 1'b0, task_switch = 1'b0, maskable_irq_pin = 1'b0;
  logic        mem_misaligned = 1'b0, mem_write = 1'b0, page_read_only = 1'b0, e;
  logic [6:0]  ev_in = 7'h00;
  logic        pready, pslverr, irq_service, step_irq, io_direct_ok, io_bitmap_chk;
  logic        io_gp_fault, debug_fault, priv_gp_fault, align_fault, wp_fault, dna_fault;
  logic        protected_mode_on, paging_enable, real_style_segments, string_dir_dec;
  logic        nested_job, cache_alloc_en;
  int          mismatches = 0, samples_checked = 0, cycles = 0;
  logic [31:0] ta [4] = '{32'hFFFF_FFFF, 32'h7FFF_FFFF, 32'h0, 32'h5};
  logic [31:0] tb [4] = '{32'h1, 32'h1, 32'h1, 32'h5};
  logic [31:0] rv [5] = '{32'h2, 32'h10, 32'h0, 32'h0, 32'h0};

  csr_core_regs dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cur_priv_level(cur_priv_level), .instr_retire(instr_retire),
    .instr_len(instr_len), .flow_load(flow_load), .flow_target(flow_target),
    .alu_valid(alu_valid), .alu_sub(alu_sub), .alu_op_a(alu_op_a), .alu_op_b(alu_op_b),
    .iret_load(iret_load), .task_switch(task_switch), .new_flags(new_flags),
    .maskable_irq_pin(maskable_irq_pin), .irq_service(irq_service),
    .io_instr(ev_in[3]), .debug_hit(ev_in[4]), .priv_opcode(ev_in[5]),
    .mem_access(ev_in[2]), .mem_misaligned(mem_misaligned), .mem_write(mem_write),
    .page_read_only(page_read_only), .page_fault(ev_in[6]),
    .fault_linear_addr(fault_linear_addr), .fpu_instr(ev_in[0]), .wait_instr(ev_in[1]),
    .step_irq(step_irq), .io_direct_ok(io_direct_ok), .io_bitmap_chk(io_bitmap_chk),
    .io_gp_fault(io_gp_fault), .debug_fault(debug_fault), .priv_gp_fault(priv_gp_fault),
    .align_fault(align_fault), .wp_fault(wp_fault), .dna_fault(dna_fault),
    .protected_mode_on(protected_mode_on), .paging_enable(paging_enable),
    .real_style_segments(real_style_segments), .string_dir_dec(string_dir_dec),
    .nested_job(nested_job), .cache_alloc_en(cache_alloc_en),
    .next_instr_offset(next_instr_offset)
  );

  initial forever #12.5 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
    apb(1'b1, a, d);
    #1 chk(e, xe);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask : rdc

  // One-cycle event pulse; all fault pulses are compared in the next cycle
  task automatic ev(input int k, input logic [5:0] x);
    @(posedge pclk);
    ev_in[k] <= 1'b1;
    @(posedge pclk);
    ev_in[k] <= 1'b0;
    #1 chk({debug_fault, priv_gp_fault, io_gp_fault, wp_fault, align_fault, dna_fault}, x);
  endtask : ev

  task automatic mv(input logic r, input logic fl, input logic [31:0] t);
    @(posedge pclk);
    instr_retire <= r;
    flow_load <= fl;
    flow_target <= t;
    @(posedge pclk);
    instr_retire <= 1'b0;
    flow_load <= 1'b0;
    #1;
  endtask : mv

  task automatic ld(input logic sw, input logic [31:0] f);
    @(posedge pclk);
    task_switch <= sw;
    iret_load <= !sw;
    new_flags <= f;
    @(posedge pclk);
    task_switch <= 1'b0;
    iret_load <= 1'b0;
  endtask : ld

  function automatic logic [31:0] calc(input logic [31:0] a, input logic [31:0] b,
                                       input logic s);
    logic [32:0] r;
    logic [31:0] f;
    r = s ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    f = 32'h0;
    f[0] = r[32];
    f[2] = ~^r[7:0];
    f[4] = a[4] ^ b[4] ^ r[4];
    f[6] = (r[31:0] == 32'h0);
    f[7] = r[31];
    f[11] = ((a[31] ^ s) == b[31]) ? (r[31] != a[31]) : 1'b0;
    return f;
  endfunction : calc

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) rdc(8'(4 * i), rv[i]);
    wr(8'h14, 32'h0, 1'b1);
    wr(8'h10, 32'h5, 1'b1);
    wr(8'h00, 32'hFFFF_FFFF, 1'b0);
    rdc(8'h00, 32'h0005_7FD7);
    chk({string_dir_dec, nested_job}, 2'b10);
    wr(8'h00, 32'h0, 1'b0);
    chk(string_dir_dec, 1'b0);
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      alu_valid <= 1'b1;
      alu_sub <= (i > 1);
      alu_op_a <= ta[i];
      alu_op_b <= tb[i];
      @(posedge pclk);
      alu_valid <= 1'b0;
      apb(1'b0, 8'h00, 32'h0);
      chk(q & 32'h0000_08D5, calc(ta[i], tb[i], i > 1));
    end
    @(posedge pclk) maskable_irq_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    #1 chk(irq_service, 1'b0);
    wr(8'h00, 32'h0000_0200, 1'b0);
    repeat (8) @(posedge pclk);
    #1 chk(irq_service, 1'b1);
    @(posedge pclk) maskable_irq_pin <= 1'b0;
    wr(8'h00, 32'h0000_0100, 1'b0);
    mv(1'b0, 1'b1, 32'h0000_1000);
    mv(1'b1, 1'b0, 32'h0);
    chk({step_irq, next_instr_offset}, {1'b1, 32'h0000_1003});
    mv(1'b1, 1'b1, 32'h0000_2000);
    chk({step_irq, next_instr_offset}, {1'b0, 32'h0000_2000});
    rdc(8'h10, 32'h0000_2000);
    rdc(8'h00, 32'h0000_0002);
    wr(8'h00, 32'h0001_0000, 1'b0);
    ev(4, 6'h00);
    mv(1'b1, 1'b0, 32'h0);
    ev(4, 6'h20);
    wr(8'h04, 32'hFFFF_FFFF, 1'b0);
    rdc(8'h04, 32'hC005_001F);
    chk({protected_mode_on, paging_enable, cache_alloc_en}, 3'b110);
    ev(0, 6'h01);
    @(posedge pclk) fault_linear_addr <= 32'h1234_5678;
    ev(6, 6'h00);
    rdc(8'h08, 32'h1234_5678);
    wr(8'h0C, 32'hFFFF_FFFF, 1'b0);
    rdc(8'h0C, 32'hFFFF_F000);
    wr(8'h00, 32'h0004_4000, 1'b0);
    chk(nested_job, 1'b1);
    @(posedge pclk) mem_misaligned <= 1'b1;
    ev(2, 6'h02);
    @(posedge pclk) mem_write <= 1'b1;
    @(posedge pclk) page_read_only <= 1'b1;
    ev(2, 6'h06);
    wr(8'h04, 32'h0000_0003, 1'b0);
    ev(2, 6'h00);
    ev(1, 6'h00);
    ev(0, 6'h00);
    ld(1'b1, 32'h0000_0002);
    rdc(8'h04, 32'h0000_001B);
    ev(1, 6'h01);
    ev(0, 6'h01);
    @(posedge pclk) cur_priv_level <= 2'h3;
    wr(8'h04, 32'h0, 1'b1);
    rdc(8'h04, 32'h0000_001B);
    ev(3, 6'h08);
    ev(2, 6'h04);
    ld(1'b0, 32'h0002_0002);
    ev(5, 6'h00);
    ld(1'b1, 32'h0002_0002);
    ev(5, 6'h10);
    chk(real_style_segments, 1'b1);
    @(posedge pclk) presetn <= 1'b0;
    @(posedge pclk) presetn <= 1'b1;
    rdc(8'h04, 32'h0000_0010);
    test_done();
  end

endmodule : csr_core_regs_tb

`default_nettype wire
